/* File: src/csi_card_interp.v */
// csi_card_interp.v: control-card interpreter, one card per wire
// assumes the reader presents one field word per valid cycle, in card order
`timescale 1ns/100ps
`include "csi_consts.vh"
// Summary of operation
// (R1) fields arrive start, pattern, pallet, table, levels, A x, Y1, B x, Y2-Y4, end
// (R2) start number compared with the previous accepted card's end number
// (R3) eight punch after start number: skip data, read only card numbers
// (R4) one dummy card spans a removed run via its start and end numbers
// (R5) inserted cards with equal numbers pass; order among them not checked
// (R6) identifying punch on start field bypasses the sequence comparison
// (R7) pattern code picks the carriage for each lateral target
// (R8) third target blank unless a dressing finger; moves first target's group
// (R9) fourth target blank unless two fingers; moves second target's group
// (R10) producer keeps B tool x moving away from the A bit
// (R11) producer keeps later lateral targets away from front finger carriages
// (R12) second target goes to the opposite drive; last datum without fingers
// (R13) table rotation and pallet shift start as soon as decoded
// (R14) wrap levels latched as the stop heights for A and B members
// (R15) pallet shift decoded only on long-panel machines
// (R16) backspace request re-runs the current card
// (R17) mismatch halts decoding, flag holds until operator clears it
module csi_card_interp
#(
  parameter W = `CSI_W
)
(
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire field_valid_in,
  input wire [W-1:0] field_data_in,
  input wire eight_punch_in,
  input wire ident_punch_in,
  output wire field_ready_out,
  output reg backspace_out,
  input wire [2:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  output wire irq_out,
  output reg [2:0] pattern_code_out,
  output reg [W-1:0] pallet_shift_index_out,
  output reg pallet_shift_go_out,
  output reg [W-1:0] table_rotation_index_out,
  output reg table_rotation_go_out,
  output reg [W-1:0] a_tool_wrap_level_out,
  output reg [W-1:0] b_tool_wrap_level_out,
  output reg [W-1:0] a_tool_x_target_out,
  output reg [W-1:0] b_tool_x_target_out,
  output reg [W-1:0] first_lateral_target_out,
  output reg [W-1:0] second_lateral_target_out,
  output reg [W-1:0] third_lateral_target_out,
  output reg [W-1:0] fourth_lateral_target_out,
  output reg third_present_out,
  output reg fourth_present_out,
  output wire [1:0] first_sel_out,
  output wire [1:0] second_sel_out,
  output wire [1:0] third_sel_out,
  output wire [1:0] fourth_sel_out,
  output reg card_done_out,
  output wire seq_error_out
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DATA = 2'h1;
  localparam ST_SKIP = 2'h2;
  localparam ST_HALT = 2'h3;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [3:0] field_q;
  reg [W-1:0] last_end_q;
  reg [W-1:0] card_start_number_q;
  reg have_last_q;
  reg test_card_q;
  reg dummy_q;
  reg seq_err_q;
  reg [4:0] ctrl_q;
  reg [`CSI_NE-1:0] irq_stat_q;
  reg [`CSI_NE-1:0] irq_mask_q;
  reg [`CSI_NE-1:0] ev;
  reg [1:0] first_sel_q;
  reg [1:0] second_sel_q;
  reg [1:0] third_sel_q;
  reg [1:0] fourth_sel_q;
  wire [1:0] first_sel_d;
  wire [1:0] second_sel_d;
  wire [1:0] third_sel_d;
  wire [1:0] fourth_sel_d;
  wire take;
  wire [3:0] next_field;
  wire start_ok;
  wire long_panel;
  wire pc_enable;
  wire bksp_req;
  wire clr_req;

  assign long_panel = ctrl_q[`CSI_C_LONG];
  assign pc_enable = ctrl_q[`CSI_C_PCEN];
  assign bksp_req = reg_wr_in && (reg_addr_in == `CSI_A_CTRL) && reg_wdata_in[`CSI_C_BKSP];
  assign clr_req = reg_wr_in && (reg_addr_in == `CSI_A_CTRL) && reg_wdata_in[`CSI_C_CLR];
  // reader stalls while halted or during backspace
  assign field_ready_out = (state_q != ST_HALT) && !bksp_req;
  assign take = field_valid_in && field_ready_out;
  assign seq_error_out = seq_err_q;
  assign irq_out = |(irq_stat_q & irq_mask_q);
  assign first_sel_out = first_sel_q;
  assign second_sel_out = second_sel_q;
  assign third_sel_out = third_sel_q;
  assign fourth_sel_out = fourth_sel_q;
  // equal start numbers of inserted cards compare equal, so their mutual order is unseen
  assign start_ok = ident_punch_in || !have_last_q || (field_data_in == last_end_q); // see (R2) see (R5) see (R6)

  // pattern code absent on this format: skip straight to the pallet field
  assign next_field = (field_q == `CSI_F_START && !pc_enable) ? `CSI_F_PLP : field_q + 4'h1;

  always @*
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
      begin
        if (take)
        begin
          if (!start_ok)
            state_d = ST_HALT; // see (R17)
          else if (eight_punch_in)
            state_d = ST_SKIP; // see (R3)
          else
            state_d = ST_DATA;
        end
      end
      ST_DATA:
      begin
        if (take && field_q == `CSI_F_END)
          state_d = ST_IDLE;
      end
      ST_SKIP:
      begin
        if (take)
          state_d = ST_IDLE;
      end
      ST_HALT:
      begin
        if (clr_req)
          state_d = ST_IDLE;
      end
      default:
        state_d = ST_IDLE;
    endcase
    if (bksp_req && state_q != ST_HALT)
      state_d = ST_IDLE; // see (R16)
  end

  always @*
  begin
    ev = {`CSI_NE{1'b0}};
    ev[`CSI_E_CARD] = card_done_out;
    ev[`CSI_E_SEQ] = take && state_q == ST_IDLE && !start_ok;
    ev[`CSI_E_DUMMY] = take && state_q == ST_SKIP;
    ev[`CSI_E_TEST] = take && state_q == ST_IDLE && ident_punch_in;
  end

  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      state_q <= ST_IDLE;
      field_q <= `CSI_F_START;
      last_end_q <= {W{1'b0}};
      card_start_number_q <= {W{1'b0}};
      have_last_q <= 1'b0;
      test_card_q <= 1'b0;
      dummy_q <= 1'b0;
      seq_err_q <= 1'b0;
      backspace_out <= 1'b0;
      card_done_out <= 1'b0;
      pattern_code_out <= 3'h0;
      pallet_shift_index_out <= {W{1'b0}};
      pallet_shift_go_out <= 1'b0;
      table_rotation_index_out <= {W{1'b0}};
      table_rotation_go_out <= 1'b0;
      a_tool_wrap_level_out <= {W{1'b0}};
      b_tool_wrap_level_out <= {W{1'b0}};
      a_tool_x_target_out <= {W{1'b0}};
      b_tool_x_target_out <= {W{1'b0}};
      first_lateral_target_out <= {W{1'b0}};
      second_lateral_target_out <= {W{1'b0}};
      third_lateral_target_out <= {W{1'b0}};
      fourth_lateral_target_out <= {W{1'b0}};
      third_present_out <= 1'b0;
      fourth_present_out <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      backspace_out <= bksp_req && state_q != ST_HALT; // see (R16)
      card_done_out <= 1'b0;
      pallet_shift_go_out <= 1'b0;
      table_rotation_go_out <= 1'b0;
      if (clr_req)
        seq_err_q <= 1'b0;
      if (reg_wr_in && reg_addr_in == `CSI_A_CTRL && reg_wdata_in[`CSI_C_INIT])
        have_last_q <= 1'b0;
      if (bksp_req && state_q != ST_HALT)
        field_q <= `CSI_F_START;
      else if (take)
      begin
        case (state_q)
          ST_IDLE:
          begin
            card_start_number_q <= field_data_in;
            test_card_q <= ident_punch_in;
            dummy_q <= eight_punch_in;
            if (!start_ok)
              seq_err_q <= 1'b1; // see (R17)
            else if (eight_punch_in)
              field_q <= `CSI_F_END;
            else
              field_q <= next_field;
          end
          ST_SKIP:
          begin
            // dummy end number carries the last removed card's number
            last_end_q <= field_data_in; // see (R4)
            have_last_q <= 1'b1;
            card_done_out <= 1'b1;
            field_q <= `CSI_F_START;
          end
          ST_DATA:
          begin
            field_q <= next_field; // see (R1)
            case (field_q)
              `CSI_F_PAT: pattern_code_out <= field_data_in[2:0]; // see (R7)
              `CSI_F_PLP:
              begin
                if (long_panel)
                begin
                  pallet_shift_index_out <= field_data_in; // see (R15)
                  pallet_shift_go_out <= 1'b1; // see (R13)
                end
              end
              `CSI_F_TRP:
              begin
                table_rotation_index_out <= field_data_in;
                table_rotation_go_out <= 1'b1; // see (R13)
              end
              `CSI_F_AZ: a_tool_wrap_level_out <= field_data_in; // see (R14)
              `CSI_F_BZ: b_tool_wrap_level_out <= field_data_in; // see (R14)
              `CSI_F_AX: a_tool_x_target_out <= field_data_in;
              `CSI_F_Y1: first_lateral_target_out <= field_data_in;
              `CSI_F_BX: b_tool_x_target_out <= field_data_in; // producer keeps it moving away, see (R10)
              `CSI_F_Y2: second_lateral_target_out <= field_data_in; // see (R12)
              `CSI_F_Y3:
              begin
                // a zero word stands for a blank field
                third_lateral_target_out <= field_data_in;
                third_present_out <= |field_data_in; // see (R8)
              end
              `CSI_F_Y4:
              begin
                fourth_lateral_target_out <= field_data_in;
                fourth_present_out <= |field_data_in; // see (R9)
              end
              `CSI_F_END:
              begin
                // a test card may sit anywhere, so it leaves the held end number alone
                if (!test_card_q)
                begin
                  last_end_q <= field_data_in; // see (R2) see (R6)
                  have_last_q <= 1'b1;
                end
                card_done_out <= 1'b1;
                field_q <= `CSI_F_START;
              end
              default: field_q <= `CSI_F_START;
            endcase
          end
          default: field_q <= field_q;
        endcase
      end
    end
  end

  // register file: control, status, sticky events, mask, last end, current start
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      ctrl_q <= 5'h0;
      irq_mask_q <= {`CSI_NE{1'b0}};
      irq_stat_q <= {`CSI_NE{1'b0}};
      reg_rdata_out <= 32'h0;
    end
    else
    begin
      if (reg_wr_in && reg_addr_in == `CSI_A_CTRL)
        ctrl_q <= {1'b0, reg_wdata_in[`CSI_C_PCEN], reg_wdata_in[`CSI_C_LONG], 2'b00};
      if (reg_wr_in && reg_addr_in == `CSI_A_MASK)
        irq_mask_q <= reg_wdata_in[`CSI_NE-1:0];
      // a new event in the clearing read wins over the clear
      if (reg_rd_in && reg_addr_in == `CSI_A_IRQ)
        irq_stat_q <= ev;
      else
        irq_stat_q <= irq_stat_q | ev;
      reg_rdata_out <= 32'h0;
      if (reg_rd_in)
      begin
        case (reg_addr_in)
          `CSI_A_CTRL: reg_rdata_out <= {27'h0, ctrl_q};
          `CSI_A_STAT: reg_rdata_out <= {24'h0, pattern_code_out, test_card_q, dummy_q, seq_err_q, have_last_q,
            state_q == ST_HALT};
          `CSI_A_IRQ: reg_rdata_out <= {28'h0, irq_stat_q};
          `CSI_A_MASK: reg_rdata_out <= {28'h0, irq_mask_q};
          `CSI_A_LAST: reg_rdata_out <= {{(32-W){1'b0}}, last_end_q};
          `CSI_A_CARD: reg_rdata_out <= {{(32-W){1'b0}}, card_start_number_q};
          default: reg_rdata_out <= 32'h0;
        endcase
      end
    end
  end

  // registered so the carriage selects only change on a clock edge
  always @(posedge sys_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      first_sel_q <= `CSI_CARRIAGE_AT;
      second_sel_q <= `CSI_CARRIAGE_BT;
      third_sel_q <= `CSI_CARRIAGE_AT;
      fourth_sel_q <= `CSI_CARRIAGE_BT;
    end
    else
    begin
      first_sel_q <= first_sel_d; // see (R7)
      second_sel_q <= second_sel_d; // see (R12)
      third_sel_q <= third_sel_d;
      fourth_sel_q <= fourth_sel_d;
    end
  end

  // third and fourth targets follow the groups of first and second, see (R8) see (R9)
  csi_lateral_map u_map
  (
    .pattern_code_in(pattern_code_out),
    .pc_enable_in(pc_enable),
    .first_sel_out(first_sel_d),
    .second_sel_out(second_sel_d),
    .third_sel_out(third_sel_d),
    .fourth_sel_out(fourth_sel_d)
  );
endmodule

/* File: src/csi_consts.vh */
// csi_consts.vh: constants for the control-card interpreter
// assumes inclusion by the interpreter modules and by the checker and bench files
`ifndef CSI_CONSTS_VH
`define CSI_CONSTS_VH
`define CSI_W 16
`define CSI_NF 13
`define CSI_F_START 4'h0
`define CSI_F_PAT 4'h1
`define CSI_F_PLP 4'h2
`define CSI_F_TRP 4'h3
`define CSI_F_AZ 4'h4
`define CSI_F_BZ 4'h5
`define CSI_F_AX 4'h6
`define CSI_F_Y1 4'h7
`define CSI_F_BX 4'h8
`define CSI_F_Y2 4'h9
`define CSI_F_Y3 4'ha
`define CSI_F_Y4 4'hb
`define CSI_F_END 4'hc
`define CSI_A_CTRL 3'h0
`define CSI_A_STAT 3'h1
`define CSI_A_IRQ 3'h2
`define CSI_A_MASK 3'h3
`define CSI_A_LAST 3'h4
`define CSI_A_CARD 3'h5
`define CSI_C_BKSP 0
`define CSI_C_CLR 1
`define CSI_C_LONG 2
`define CSI_C_PCEN 3
`define CSI_C_INIT 4
`define CSI_E_CARD 0
`define CSI_E_SEQ 1
`define CSI_E_DUMMY 2
`define CSI_E_TEST 3
`define CSI_NE 4
`define CSI_CARRIAGE_AT 2'h0
`define CSI_CARRIAGE_BT 2'h1
`define CSI_CARRIAGE_AFD 2'h2
`define CSI_CARRIAGE_BFD 2'h3
`endif

/* File: src/csi_lateral_map.v */
// csi_lateral_map.v: maps pattern code to carriages for the four lateral targets
// assumes a registered pattern code from the interpreter
`timescale 1ns/100ps
`include "csi_consts.vh"
module csi_lateral_map
(
  input wire [2:0] pattern_code_in,
  input wire pc_enable_in,
  output reg [1:0] first_sel_out,
  output reg [1:0] second_sel_out,
  output reg [1:0] third_sel_out,
  output reg [1:0] fourth_sel_out
);
  // first and second always on opposite drives; third/fourth follow their group
  always @*
  begin
    first_sel_out = `CSI_CARRIAGE_AT;
    second_sel_out = `CSI_CARRIAGE_BT;
    third_sel_out = `CSI_CARRIAGE_AT;
    fourth_sel_out = `CSI_CARRIAGE_BT;
    if (pc_enable_in)
    begin
      case (pattern_code_in)
        3'h1:
        begin
          first_sel_out = `CSI_CARRIAGE_AT;
          second_sel_out = `CSI_CARRIAGE_BT;
        end
        3'h2, 3'h3:
        begin
          first_sel_out = `CSI_CARRIAGE_AFD;
          second_sel_out = `CSI_CARRIAGE_BT;
          third_sel_out = `CSI_CARRIAGE_AT;
        end
        3'h4:
        begin
          first_sel_out = `CSI_CARRIAGE_AFD;
          second_sel_out = `CSI_CARRIAGE_BFD;
          third_sel_out = `CSI_CARRIAGE_AT;
          fourth_sel_out = `CSI_CARRIAGE_BT;
        end
        3'h5:
        begin
          first_sel_out = `CSI_CARRIAGE_BFD;
          second_sel_out = `CSI_CARRIAGE_AFD;
          third_sel_out = `CSI_CARRIAGE_BT;
          fourth_sel_out = `CSI_CARRIAGE_AT;
        end
        default:
        begin
          first_sel_out = `CSI_CARRIAGE_AT;
          second_sel_out = `CSI_CARRIAGE_BT;
        end
      endcase
    end
  end
endmodule

/* File: bench/csi_card_interp_asserts.sv */
// csi_card_interp_asserts.sv: port checker for the card interpreter
// assumes one clock and an async low reset; bound below
`timescale 1ns/100ps
`include "csi_consts.vh"
module csi_card_interp_asserts
#(
  parameter W = 16
)
(
  input wire sys_clk_in,
  input wire rst_n_in,
  input wire field_valid_in,
  input wire eight_punch_in,
  input wire ident_punch_in,
  input wire field_ready_out,
  input wire backspace_out,
  input wire [2:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire pallet_shift_go_out,
  input wire table_rotation_go_out,
  input wire [W-1:0] third_lateral_target_out,
  input wire [W-1:0] fourth_lateral_target_out,
  input wire third_present_out,
  input wire fourth_present_out,
  input wire card_done_out,
  input wire seq_error_out
);
  wire ctl_w = reg_wr_in && reg_addr_in == `CSI_A_CTRL;
  wire take_w = field_valid_in && field_ready_out;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  a_halt_blocks: assert property (seq_error_out |-> !field_ready_out)
    else $error("ready high while halted");
  a_error_holds: assert property (seq_error_out && !(ctl_w && reg_wdata_in[`CSI_C_CLR]) |=> seq_error_out)
    else $error("error flag dropped alone");
  a_clear_works: assert property (ctl_w && reg_wdata_in[`CSI_C_CLR] |=> !seq_error_out)
    else $error("clear ignored");
  a_error_cause: assert property ($rose(seq_error_out) |-> $past(take_w && !ident_punch_in))
    else $error("error without a checked word");
  a_bksp_pulse: assert property (ctl_w && reg_wdata_in[`CSI_C_BKSP] && !seq_error_out
    |=> backspace_out ##1 !backspace_out)
    else $error("backspace pulse wrong");
  a_done_cause: assert property (card_done_out |-> $past(take_w))
    else $error("done without a taken word");
  a_go_prompt: assert property (table_rotation_go_out |-> $past(take_w) ##1 !table_rotation_go_out)
    else $error("rotation start wrong");
  a_dummy_quiet: assert property (take_w && eight_punch_in
    |=> (!table_rotation_go_out && !pallet_shift_go_out)[*3])
    else $error("motion on a dummy card");
  a_third_flag: assert property (third_present_out == (|third_lateral_target_out))
    else $error("third flag wrong");
  a_fourth_flag: assert property (fourth_present_out == (|fourth_lateral_target_out))
    else $error("fourth flag wrong");
  c_done: cover property (card_done_out);
  c_error: cover property ($rose(seq_error_out));
  c_bksp: cover property (backspace_out);
endmodule
bind csi_card_interp csi_card_interp_asserts #(.W(W)) csi_card_interp_asserts_i (.sys_clk_in(sys_clk_in),
  .rst_n_in(rst_n_in), .field_valid_in(field_valid_in), .eight_punch_in(eight_punch_in),
  .ident_punch_in(ident_punch_in), .field_ready_out(field_ready_out), .backspace_out(backspace_out),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in),
  .pallet_shift_go_out(pallet_shift_go_out), .table_rotation_go_out(table_rotation_go_out),
  .third_lateral_target_out(third_lateral_target_out), .fourth_lateral_target_out(fourth_lateral_target_out),
  .third_present_out(third_present_out), .fourth_present_out(fourth_present_out),
  .card_done_out(card_done_out), .seq_error_out(seq_error_out));

/* File: bench/csi_reader_model.sv */
// csi_reader_model.sv: card reader model, one field word per send call
// assumes ready is sampled at rising edges; slow adds idle cycles
`timescale 1ns/100ps
module csi_reader_model
(
  input wire sys_clk_in,
  input wire field_ready_in,
  output logic field_valid_out = 1'b0,
  output logic [15:0] field_data_out = 16'h0,
  output logic eight_punch_out = 1'b0,
  output logic ident_punch_out = 1'b0
);
  int slow = 0;
  // words leave in card order as the caller gives them
  task automatic send(input logic [15:0] w, input logic e8, input logic id, output logic ok);
    int n;
    begin
      n = 0;
      repeat (slow + 1) @(posedge sys_clk_in);
      field_valid_out <= 1'b1;
      field_data_out <= w;
      eight_punch_out <= e8;
      ident_punch_out <= id;
      do
      begin
        @(posedge sys_clk_in);
        n++;
      end
      while (field_ready_in !== 1'b1 && n < 50);
      ok = field_ready_in === 1'b1;
      // released lines show the inverse so a stale word is never reused
      field_valid_out <= 1'b0;
      field_data_out <= ~w;
      eight_punch_out <= ~e8;
      ident_punch_out <= ~id;
    end
  endtask
endmodule

/* File: bench/csi_card_interp_tb.sv */
// csi_card_interp_tb.sv: self-checking bench for the card interpreter
// assumes the reader model feeds fields and the checker is bound
`timescale 1ns/100ps
`include "csi_consts.vh"
module csi_card_interp_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ok;
  logic [31:0] v;
  wire vld, rdy, ep, ip, bk, irq, done, serr, tgo, pgo, t3, t4;
  wire [15:0] fd, pal, tab, az, bz, ax, bx, y1, y2, y3, y4;
  wire [1:0] s1, s2, s3, s4;
  wire [2:0] pc;
  wire [31:0] rdata;
  int errors = 0;
  int n_compared = 0;
  int n_done = 0;
  int n_go = 0;
  int n_bk = 0;
  int n_pg = 0;
  always #2.5 clk = ~clk;
  always @(posedge clk)
  begin
    if (done === 1'b1) n_done++;
    if (tgo === 1'b1) n_go++;
    if (bk === 1'b1) n_bk++;
    if (pgo === 1'b1) n_pg++;
  end
  csi_reader_model csi_reader_model_i (.sys_clk_in(clk), .field_ready_in(rdy), .field_valid_out(vld),
    .field_data_out(fd), .eight_punch_out(ep), .ident_punch_out(ip));
  csi_card_interp #(.W(16)) csi_card_interp_i (.sys_clk_in(clk), .rst_n_in(rst_n), .field_valid_in(vld),
    .field_data_in(fd), .eight_punch_in(ep), .ident_punch_in(ip), .field_ready_out(rdy), .backspace_out(bk),
    .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .irq_out(irq), .pattern_code_out(pc), .pallet_shift_index_out(pal), .pallet_shift_go_out(pgo),
    .table_rotation_index_out(tab), .table_rotation_go_out(tgo), .a_tool_wrap_level_out(az),
    .b_tool_wrap_level_out(bz), .a_tool_x_target_out(ax), .b_tool_x_target_out(bx),
    .first_lateral_target_out(y1), .second_lateral_target_out(y2), .third_lateral_target_out(y3),
    .fourth_lateral_target_out(y4), .third_present_out(t3), .fourth_present_out(t4), .first_sel_out(s1),
    .second_sel_out(s2), .third_sel_out(s3), .fourth_sel_out(s4), .card_done_out(done), .seq_error_out(serr));
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    begin
      n_compared++;
      if (g !== e)
      begin
        errors++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  task automatic wreg(input logic [2:0] a, input logic [31:0] d);
    begin
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
    end
  endtask
  task automatic rreg(input logic [2:0] a);
    begin
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
      v = rdata;
    end
  endtask
  task automatic card(input logic [15:0] s, input logic [15:0] e, input logic [2:0] p,
    input logic [15:0] f3, input logic [15:0] f4, input logic id, input logic pe);
    logic [15:0] f[13];
    begin
      // b tool x and later targets move away from earlier ones
      f = '{s, {13'h0, p}, s ^ 16'h5a00, 16'h0b02, 16'h0001, 16'h0002, 16'h0c03, 16'h0d04, 16'h0e05,
        16'h0f06, f3, f4, e};
      for (int i = 0; i < 13; i++)
      begin
        if (i != 1 || pe)
          csi_reader_model_i.send(f[i], 1'b0, id & (i == 0), ok);
      end
      repeat (2) @(posedge clk);
    end
  endtask
  task automatic t_patterns;
    begin
      wreg(`CSI_A_CTRL, 32'hc);
      for (logic [3:0] p = 0; p < 8; p++)
      begin
        card({12'h001, p}, {12'h001, p} + 16'h1, p[2:0], p[0] ? 16'h0 : 16'h7, p[1] ? 16'h8 : 16'h0, 1'b0, 1'b1);
        chk({pc, s1[0] ^ s2[0], s4[0] ^ s2[0], serr}, {p[2:0], 3'b100});
        chk({t3, t4}, {~p[0], p[1]});
      end
      chk({pal, tab}, 32'h5a170b02);
      chk({az, bz}, 32'h00010002);
      chk({ax, y1}, 32'h0c030d04);
      chk({bx, y2}, 32'h0e050f06);
      chk({y3, y4}, 32'h00000008);
      chk(n_go, 8);
      chk(n_pg, 8);
      rreg(`CSI_A_LAST);
      chk(v, 32'h18);
      $display("t_patterns done");
    end
  endtask
  task automatic t_dummy_insert;
    begin
      rreg(`CSI_A_IRQ);
      csi_reader_model_i.send(16'h18, 1'b1, 1'b0, ok);
      csi_reader_model_i.send(16'h30, 1'b0, 1'b0, ok);
      repeat (2) @(posedge clk);
      chk({y1, 8'(n_go), 7'h0, serr}, {16'h0d04, 8'h8, 8'h0});
      rreg(`CSI_A_IRQ);
      chk({v[30:0], irq}, {31'h5, 1'b0}); // masked events
      card(16'h30, 16'h31, 3'h0, 16'h0, 16'h0, 1'b0, 1'b1);
      card(16'h31, 16'h31, 3'h1, 16'h7, 16'h0, 1'b0, 1'b1);
      card(16'h31, 16'h31, 3'h2, 16'h0, 16'h8, 1'b0, 1'b1);
      card(16'h31, 16'h32, 3'h3, 16'h7, 16'h8, 1'b0, 1'b1);
      chk({serr, 8'(n_done)}, {1'b0, 8'd13});
      rreg(`CSI_A_IRQ);
      card(16'h7777, 16'h7778, 3'h4, 16'h7, 16'h0, 1'b1, 1'b1);
      rreg(`CSI_A_IRQ);
      chk({v[30:0], serr}, {31'h9, 1'b0});
      rreg(`CSI_A_LAST);
      chk(v, 32'h32);
      $display("t_dummy_insert done");
    end
  endtask
  task automatic t_mismatch;
    begin
      wreg(`CSI_A_MASK, 32'h2);
      csi_reader_model_i.send(16'h99, 1'b0, 1'b0, ok);
      csi_reader_model_i.send(16'h01, 1'b0, 1'b0, ok);
      chk({serr, rdy, irq, ok}, 4'b1010);
      rreg(`CSI_A_STAT);
      chk(v, 32'h87);
      rreg(`CSI_A_CARD);
      chk(v, 32'h99);
      rreg(`CSI_A_MASK);
      chk(v, 32'h2);
      rreg(`CSI_A_IRQ);
      chk({v[30:0], irq}, {31'h2, 1'b0});
      wreg(`CSI_A_CTRL, 32'he);
      rreg(3'h6);
      chk(v, 32'h0);
      chk({serr, rdy}, 2'b01);
      // forgetting the held end number lets any start through
      wreg(`CSI_A_CTRL, 32'h1c);
      card(16'h0500, 16'h32, 3'h1, 16'h7, 16'h0, 1'b0, 1'b1);
      rreg(`CSI_A_STAT);
      chk(v, 32'h22);
      rreg(`CSI_A_CTRL);
      chk(v, 32'hc);
      $display("t_mismatch done");
    end
  endtask
  task automatic t_backspace_short;
    begin
      csi_reader_model_i.send(16'h32, 1'b0, 1'b0, ok);
      wreg(`CSI_A_CTRL, 32'hd);
      repeat (2) @(posedge clk);
      chk(n_bk, 1);
      card(16'h32, 16'h33, 3'h5, 16'h7, 16'h8, 1'b0, 1'b1);
      chk(serr, 0);
      // no long panel and no pattern field: pallet held, default carriages
      wreg(`CSI_A_CTRL, 32'h0);
      csi_reader_model_i.slow = 3;
      card(16'h33, 16'h34, 3'h0, 16'h0, 16'h0, 1'b0, 1'b0);
      chk({pal, s1, s2, s3, s4, serr}, {16'h5a32, 8'h11, 1'b0});
      chk(n_go - n_pg, 1);
      $display("t_backspace_short done");
    end
  endtask
  task automatic results;
    begin
      $display("compared=%0d errors=%0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("Run complete: PASS");
      else
        $display("Run complete: FAIL");
      $finish;
    end
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_patterns;
    t_dummy_insert;
    t_mismatch;
    t_backspace_short;
    results;
  end
  initial
  begin
    #200000;
    errors++;
    results;
  end
endmodule
